/* File: core/caldp_core.sv */
// Purpose: byte/word arithmetic and logic execution with condition flags
// Assumes: req_valid marks one operation per cycle; results one cycle later
// Notes: half-carry is kept internally for decimal adjust
//
// How it works
// - plus and minus on two registers; immediate only for plus.
// - word plus and minus only with two register operands.
// - carry and borrow forms are byte only, register or immediate.
// - step up and step down add or subtract one on a byte.
// - word small adjust adds or subtracts one or two only.
// - decimal adjust after plus or minus chosen from flags.
// - unsigned 8 by 8 multiply gives a 16-bit product.
// - unsigned 16 by 8 divide gives 8-bit quotient and remainder.
// - compare subtracts and updates flags without write back.
// - word compare only between two registers.
// - negate writes zero minus the byte value.
// - byte AND with register or immediate.
// - byte OR with register or immediate.
// - byte XOR with register or immediate.
// - invert every bit of a byte register.
// - direction zero is peripheral load, one is peripheral store.
// - flags hold negative, zero, overflow, carry; carry feeds carry ops.
`timescale 1ns/1ps

module caldp_core
	import caldp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Request
	input wire logic req_valid,
	input wire caldp_req_t req,
	// Answer
	output logic rsp_valid,
	output caldp_rsp_t rsp,
	output caldp_flags_t flags
);

	////////////////////////////////////////////////////////////////////////
	// Adder shared by all additive operations except the two decimal adjusts
	typedef struct packed {
		logic [15:0] sum;
		logic carry;
		logic ovf;
		logic half;
	} caldp_add_t;

	function automatic caldp_add_t caldp_add(input logic [15:0] a, input logic [15:0] b,
		input logic cin, input logic sub, input logic word);
		caldp_add_t r;
		logic [16:0] full;
		logic [8:0] byte_sum;
		logic [4:0] nib;
		logic [15:0] bb;
		r = '0;
		bb = sub ? ~b : b;
		if (word) begin
			full = {1'b0, a} + {1'b0, bb} + {16'h0000, cin ^ sub};
			r.sum = full[15:0];
			r.carry = full[16] ^ sub;
			r.ovf = (a[15] == bb[15]) && (full[15] != a[15]);
			r.half = 1'b0;
		end else begin
			byte_sum = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin ^ sub};
			nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
			r.sum = {8'h00, byte_sum[7:0]};
			r.carry = byte_sum[8] ^ sub;
			r.ovf = (a[7] == bb[7]) && (byte_sum[7] != a[7]);
			r.half = nib[4] ^ sub;
		end
		return r;
	endfunction : caldp_add

	////////////////////////////////////////////////////////////////////////
	// Registered state
	caldp_flags_t flags_ff, nxt_flags;
	logic half_ff, nxt_half;
	logic rsp_valid_ff, nxt_rsp_valid;
	caldp_rsp_t rsp_ff, nxt_rsp;

	// Working signals
	caldp_add_t add_r;
	logic [7:0] opnd;
	logic [7:0] adj;
	logic [8:0] bcd_sum;
	logic [15:0] prod;
	logic [7:0] quot;
	logic [7:0] rem;
	logic [15:0] res;
	logic wr;
	logic ill;
	logic arith;
	logic set_nz;
	logic wide; // Flags taken from bit 15 for true word forms

	// Byte operand: register or immediate
	assign opnd = req.use_imm ? req.imm : req.src[7:0];

	// Multiply and divide
	assign prod = {8'h00, req.dst[7:0]} * {8'h00, req.src[7:0]};
	assign quot = (req.src[7:0] == 8'h00) ? 8'hFF : 8'((req.dst / {8'h00, req.src[7:0]}));
	assign rem = (req.src[7:0] == 8'h00) ? req.dst[7:0] : 8'((req.dst % {8'h00, req.src[7:0]}));

	////////////////////////////////////////////////////////////////////////
	// Operation decode and next values
	always_comb begin
		nxt_flags = flags_ff;
		nxt_half = half_ff;
		nxt_rsp_valid = req_valid;
		nxt_rsp = rsp_ff;
		add_r = '0;
		adj = 8'h00;
		bcd_sum = 9'h000;
		res = CALDP_RESULT_RST;
		wr = 1'b0;
		ill = 1'b0;
		arith = 1'b0;
		set_nz = 1'b0;
		wide = 1'b0;
		unique case (req.op)
			// Plus, immediate only for bytes
			CALDP_OP_PLUS: begin
				ill = req.word && req.use_imm;
				wide = req.word;
				add_r = caldp_add(req.dst, req.use_imm ? {8'h00, req.imm} : req.src, 1'b0, 1'b0, req.word);
				res = add_r.sum;
				wr = 1'b1;
				arith = 1'b1;
			end
			// Minus, registers only
			CALDP_OP_MINUS: begin
				wide = req.word;
				ill = req.use_imm;
				add_r = caldp_add(req.dst, req.src, 1'b0, 1'b1, req.word);
				res = add_r.sum;
				wr = 1'b1;
				arith = 1'b1;
			end
			// Carry forms; on minus the carry acts as the borrow in
			CALDP_OP_PLUS_C, CALDP_OP_MINUS_B: begin
				ill = req.word;
				add_r = caldp_add(req.dst, {8'h00, opnd}, flags_ff.carry,
					req.op == CALDP_OP_MINUS_B, 1'b0);
				res = add_r.sum;
				wr = 1'b1;
				arith = 1'b1;
			end
			// Step by one, carry kept
			CALDP_OP_STEP_UP, CALDP_OP_STEP_DN: begin
				ill = req.word;
				add_r = caldp_add(req.dst, {8'h00, CALDP_SMALL_ONE}, 1'b0,
					req.op == CALDP_OP_STEP_DN, 1'b0);
				res = add_r.sum;
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.ovf = add_r.ovf;
			end
			// Word small adjust, flags untouched
			CALDP_OP_WPLUS_S, CALDP_OP_WMINUS_S: begin
				ill = (req.imm != CALDP_SMALL_ONE) && (req.imm != CALDP_SMALL_TWO);
				add_r = caldp_add(req.dst, {8'h00, req.imm}, 1'b0, req.op == CALDP_OP_WMINUS_S, 1'b1);
				res = add_r.sum;
				wr = 1'b1;
			end
			// Decimal adjust after an addition
			CALDP_OP_BCD_PLUS: begin
				// Correction from carry and half-carry plus digit range
				if (half_ff || (req.dst[3:0] > 4'h9)) begin
					adj = adj | CALDP_BCD_LO;
				end
				if (flags_ff.carry || (req.dst[7:0] > 8'h99)) begin
					adj = adj | CALDP_BCD_HI;
				end
				bcd_sum = {1'b0, req.dst[7:0]} + {1'b0, adj};
				res = {8'h00, bcd_sum[7:0]};
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.carry = flags_ff.carry || bcd_sum[8];
			end
			// Decimal adjust after a subtraction
			CALDP_OP_BCD_MINUS: begin
				if (half_ff) begin
					adj = adj | CALDP_BCD_LO;
				end
				if (flags_ff.carry) begin
					adj = adj | CALDP_BCD_HI;
				end
				res = {8'h00, 8'(req.dst[7:0] - adj)};
				wr = 1'b1;
				set_nz = 1'b1;
			end
			// Unsigned product, no flags
			CALDP_OP_MULU: begin
				res = prod;
				wr = 1'b1;
			end
			// Unsigned divide, zero divisor flagged
			CALDP_OP_DIVU: begin
				res = {rem, quot};
				wr = 1'b1;
				nxt_flags.neg = quot[7];
				nxt_flags.zero = (req.src[7:0] == 8'h00);
			end
			// Compare, flags only
			CALDP_OP_CMP: begin
				ill = req.word && req.use_imm;
				wide = req.word;
				add_r = caldp_add(req.dst, req.use_imm ? {8'h00, req.imm} : req.src, 1'b0, 1'b1, req.word);
				res = add_r.sum;
				wr = 1'b0;
				arith = 1'b1;
			end
			// Negate as zero minus value
			CALDP_OP_NEG: begin
				add_r = caldp_add(16'h0000, req.dst, 1'b0, 1'b1, 1'b0);
				res = add_r.sum;
				wr = 1'b1;
				arith = 1'b1;
			end
			// Logic ops clear overflow, keep carry
			CALDP_OP_AND: begin
				res = {8'h00, req.dst[7:0] & opnd};
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.ovf = 1'b0;
			end
			CALDP_OP_OR: begin
				res = {8'h00, req.dst[7:0] | opnd};
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.ovf = 1'b0;
			end
			CALDP_OP_XOR: begin
				res = {8'h00, req.dst[7:0] ^ opnd};
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.ovf = 1'b0;
			end
			CALDP_OP_NOT: begin
				res = {8'h00, ~req.dst[7:0]};
				wr = 1'b1;
				set_nz = 1'b1;
				nxt_flags.ovf = 1'b0;
			end
			// Peripheral transfer, direction only
			CALDP_OP_PXFER: begin
				res = {8'h00, req.src[7:0]};
				wr = 1'b0;
			end
			// Unused codes are refused
			default: begin
				ill = 1'b1;
			end
		endcase
		// Flag update from the result
		if (arith) begin
			set_nz = 1'b1;
			nxt_flags.ovf = add_r.ovf;
			nxt_flags.carry = add_r.carry;
			nxt_half = add_r.half;
		end
		if (set_nz) begin
			nxt_flags.neg = wide ? res[15] : res[7];
			nxt_flags.zero = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
		end
		// Illegal forms change nothing
		if (!req_valid || ill) begin
			nxt_flags = flags_ff;
			nxt_half = half_ff;
		end
		if (req_valid) begin
			nxt_rsp.result = ill ? CALDP_RESULT_RST : res;
			nxt_rsp.write_back = wr && !ill;
			nxt_rsp.illegal = ill;
			nxt_rsp.pxfer_load = (req.op == CALDP_OP_PXFER) && (req.dir == CALDP_DIR_LOAD);
			nxt_rsp.pxfer_store = (req.op == CALDP_OP_PXFER) && (req.dir == CALDP_DIR_STORE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_ff <= CALDP_FLAGS_RST;
			half_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
			half_ff <= nxt_half;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_ff <= nxt_rsp;
		end
	end

	// Outputs
	assign rsp_valid = rsp_valid_ff;
	assign rsp = rsp_ff;
	assign flags = flags_ff;

endmodule : caldp_core

/* File: inc/caldp_pkg.sv */
// Purpose: shared types and constants of the arithmetic and logic datapath
// Assumes: one clock, operands supplied by the register file outside
// Notes: operation codes are local to this block
package caldp_pkg;

	// Operation codes
	typedef enum logic [4:0] {
		CALDP_OP_PLUS = 5'h00,
		CALDP_OP_MINUS = 5'h01,
		CALDP_OP_PLUS_C = 5'h02,
		CALDP_OP_MINUS_B = 5'h03,
		CALDP_OP_STEP_UP = 5'h04,
		CALDP_OP_STEP_DN = 5'h05,
		CALDP_OP_WPLUS_S = 5'h06,
		CALDP_OP_WMINUS_S = 5'h07,
		CALDP_OP_BCD_PLUS = 5'h08,
		CALDP_OP_BCD_MINUS = 5'h09,
		CALDP_OP_MULU = 5'h0A,
		CALDP_OP_DIVU = 5'h0B,
		CALDP_OP_CMP = 5'h0C,
		CALDP_OP_NEG = 5'h0D,
		CALDP_OP_AND = 5'h0E,
		CALDP_OP_OR = 5'h0F,
		CALDP_OP_XOR = 5'h10,
		CALDP_OP_NOT = 5'h11,
		CALDP_OP_PXFER = 5'h12
	} caldp_op_t;

	// Condition flags
	typedef struct packed {
		logic neg;
		logic zero;
		logic ovf;
		logic carry;
	} caldp_flags_t;

	// One request to the datapath
	typedef struct packed {
		caldp_op_t op;
		logic word;
		logic use_imm;
		logic [15:0] dst;
		logic [15:0] src;
		logic [7:0] imm;
		logic dir;
	} caldp_req_t;

	// One answer of the datapath
	typedef struct packed {
		logic [15:0] result;
		logic write_back;
		logic illegal;
		logic pxfer_store;
		logic pxfer_load;
	} caldp_rsp_t;

	localparam caldp_flags_t CALDP_FLAGS_RST = 4'h0;
	localparam logic [15:0] CALDP_RESULT_RST = 16'h0000;
	localparam logic [7:0] CALDP_SMALL_ONE = 8'h01;
	localparam logic [7:0] CALDP_SMALL_TWO = 8'h02;
	localparam logic CALDP_DIR_LOAD = 1'h0;
	localparam logic CALDP_DIR_STORE = 1'h1;
	localparam logic [7:0] CALDP_BCD_LO = 8'h06;
	localparam logic [7:0] CALDP_BCD_HI = 8'h60;

endpackage : caldp_pkg

/* File: sim/caldp_props.sv */
// Purpose: timing and result checks of the datapath ports
// Assumes: one clock, reset high while asserted
// Notes: bound to the core from the bench
`timescale 1ns/1ps

module caldp_props
	import caldp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Request
	input wire logic req_valid,
	input wire caldp_req_t req,
	// Answer
	input wire logic rsp_valid,
	input wire caldp_rsp_t rsp,
	input wire caldp_flags_t flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////
	// Answer timing, refusals and results
	AST_VALID: assert property (rsp_valid == $past(req_valid))
		else $error("answer strobe off");
	AST_CMP: assert property (req_valid && req.op == CALDP_OP_CMP |=> rsp_valid && !rsp.write_back)
		else $error("compare wrote back");
	AST_NOT: assert property (req_valid && req.op == CALDP_OP_NOT && !req.word |=>
		rsp.result == {8'h00, ~$past(req.dst[7:0])}) else $error("invert wrong");
	AST_NEG: assert property (req_valid && req.op == CALDP_OP_NEG && !req.word |=>
		rsp.result[7:0] == 8'h00 - $past(req.dst[7:0])) else $error("negate wrong");
	AST_MINI: assert property (req_valid && req.op == CALDP_OP_MINUS && req.use_imm |=>
		rsp.illegal && !rsp.write_back) else $error("minus imm taken");
	AST_WIMM: assert property (req_valid && req.word && req.use_imm &&
		(req.op == CALDP_OP_PLUS || req.op == CALDP_OP_CMP) |=> rsp.illegal) else $error("word imm taken");
	AST_MUL: assert property (req_valid && req.op == CALDP_OP_MULU |=>
		rsp.result == $past(req.dst[7:0]) * $past(req.src[7:0])) else $error("product wrong");
	AST_DIR: assert property (req_valid && req.op == CALDP_OP_PXFER |=>
		rsp.pxfer_store == $past(req.dir) && rsp.pxfer_load == !$past(req.dir)) else $error("direction wrong");
	AST_HOLD: assert property (rsp_valid && rsp.illegal |-> $stable(flags))
		else $error("flags moved on refusal");
	AST_STEP: assert property (req_valid && req.op == CALDP_OP_STEP_UP && !req.word |=>
		rsp.result[7:0] == $past(req.dst[7:0]) + 8'h01) else $error("step wrong");

	// Main scenarios seen
	cover property (req_valid && req.op == CALDP_OP_DIVU);
	cover property (req_valid && req.op == CALDP_OP_BCD_MINUS);
	cover property (rsp_valid && rsp.illegal);
endmodule : caldp_props

/* File: sim/caldp_tb.sv */
// Purpose: self-checking bench of the datapath
// Assumes: answers one cycle after each taken request
// Notes: masks skip flag bits the ops leave open
`timescale 1ns/1ps

module tb;
	import caldp_pkg::*;
	logic clk, sys_rst, req_valid, rsp_valid;
	caldp_req_t req;
	caldp_rsp_t rsp;
	caldp_flags_t flags;
	int bad_count, compares;
	logic [47:0] q[$];
	logic [23:0] x, m;
	logic [7:0] a, b, r;
	caldp_op_t bad_ops[5] = '{CALDP_OP_PLUS, CALDP_OP_CMP, CALDP_OP_PLUS_C, CALDP_OP_STEP_UP, CALDP_OP_WPLUS_S};

	caldp_core dut(.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
		.rsp(rsp), .flags(flags));

	////////////////////////////////////////////////////////////////
	// Expected answer and byte flags
	function automatic logic [23:0] e(input logic [15:0] v, input logic wb, il, input logic [3:0] f);
		return {v, wb, il, 2'b00, f};
	endfunction : e
	function automatic logic [1:0] nz(input logic [7:0] v);
		return {v[7], v == 8'h00};
	endfunction : nz

	// One request per cycle, note kept
	task go(input caldp_op_t o, input logic w, im, dr, input logic [15:0] d, s, input logic [7:0] i,
		input logic [23:0] ex, mk);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req = '{o, w, im, d, s, i, dr};
		q.push_back({mk, ex});
	endtask : go

	task stop_test;
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Answer watcher
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			compares++;
			{m, x} = q.pop_front();
			if ((({rsp, flags} ^ x) & m) !== 24'h0) begin
				bad_count++;
				$display("[ERR] rsp exp %h got %h", x, {rsp, flags});
			end
		end
	end

	// Watchdog
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// Stimulus
	initial begin
		void'($urandom(32'hb1ef));
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		go(CALDP_OP_PLUS, 0, 0, 0, 16'h0001, 16'h00FF, 8'h00, e(16'h0, 1, 0, 4'h5), 24'hFFFFFF);
		for (int k = 0; k < 12; k++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			case (k % 3)
				0: r = a & b;
				1: r = a | b;
				default: r = a ^ b;
			endcase
			go(caldp_op_t'(5'h0E + 5'(k % 3)), 0, k[2], 0, {8'hA5, a}, {8'h5A, k[2] ? 8'h00 : b}, k[2] ? b : 8'h00,
				e({8'h00, r}, 1, 0, {nz(r), 2'b00}), 24'hFFFFFE);
		end
		go(CALDP_OP_NOT, 0, 0, 0, {8'h3C, a}, 16'h0, 8'h00, e({8'h00, ~a}, 1, 0, {nz(~a), 2'b00}), 24'hFFFFFE);
		go(CALDP_OP_NEG, 0, 0, 0, 16'h0080, 16'h0, 8'h00, e(16'h0080, 1, 0, 4'hB), 24'hFFFFFF);
		go(CALDP_OP_MINUS, 0, 1, 0, 16'h0010, 16'h0, 8'h01, e(16'h0, 0, 1, 4'h0), 24'hFFFFF0);
		foreach (bad_ops[j])
			go(bad_ops[j], 1, 1, 0, 16'h1234, 16'h0, 8'h03, e(16'h0, 0, 1, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_PLUS, 1, 0, 0, 16'h7FFF, 16'h0001, 8'h00, e(16'h8000, 1, 0, 4'hA), 24'hFFFFFF);
		go(CALDP_OP_MINUS, 1, 0, 0, 16'h0000, 16'h0001, 8'h00, e(16'hFFFF, 1, 0, 4'h9), 24'hFFFFFF);
		go(CALDP_OP_CMP, 0, 1, 0, 16'h0042, 16'h0, 8'h42, e(16'h0, 0, 0, 4'h4), 24'h0000FF);
		go(CALDP_OP_CMP, 1, 0, 0, 16'h0001, 16'h0002, 8'h00, e(16'h0, 0, 0, 4'h9), 24'h0000FF);
		go(CALDP_OP_STEP_UP, 0, 0, 0, 16'h00FF, 16'h0, 8'h00, e(16'h0, 1, 0, 4'h4), 24'hFFFFFE);
		go(CALDP_OP_STEP_DN, 0, 0, 0, 16'h0080, 16'h0, 8'h00, e(16'h007F, 1, 0, 4'h2), 24'hFFFFFE);
		go(CALDP_OP_WPLUS_S, 1, 1, 0, 16'hFFFF, 16'h0, 8'h02, e(16'h0001, 1, 0, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_WMINUS_S, 1, 1, 0, 16'h0001, 16'h0, 8'h01, e(16'h0, 1, 0, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_MULU, 0, 0, 0, 16'h00FF, 16'h00FF, 8'h00, e(16'hFE01, 1, 0, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_DIVU, 0, 0, 0, 16'h0403, 16'h0010, 8'h00, e(16'h0340, 1, 0, 4'h0), 24'hFFFFFC);
		go(CALDP_OP_DIVU, 0, 0, 0, 16'h1234, 16'h0000, 8'h00, e(16'h34FF, 1, 0, 4'hC), 24'hFFFFFC);
		go(CALDP_OP_PLUS, 0, 0, 0, 16'h0080, 16'h0080, 8'h00, e(16'h0, 1, 0, 4'h7), 24'hFFFFFF);
		go(CALDP_OP_PLUS_C, 0, 0, 0, 16'h0001, 16'h0001, 8'h00, e(16'h0003, 1, 0, 4'h0), 24'hFFFFFF);
		go(CALDP_OP_MINUS_B, 0, 1, 0, 16'h0005, 16'h0, 8'h03, e(16'h0002, 1, 0, 4'h0), 24'hFFFFFF);
		go(CALDP_OP_PLUS, 0, 0, 0, 16'h0015, 16'h0027, 8'h00, e(16'h003C, 1, 0, 4'h0), 24'hFFFFFF);
		go(CALDP_OP_BCD_PLUS, 0, 0, 0, 16'h003C, 16'h0, 8'h00, e(16'h0042, 1, 0, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_MINUS, 0, 0, 0, 16'h0042, 16'h0015, 8'h00, e(16'h002D, 1, 0, 4'h0), 24'hFFFFFF);
		go(CALDP_OP_BCD_MINUS, 0, 0, 0, 16'h002D, 16'h0, 8'h00, e(16'h0027, 1, 0, 4'h0), 24'hFFFFF0);
		go(CALDP_OP_PXFER, 0, 0, 0, 16'h0, 16'h55AA, 8'h00, {16'h00AA, 4'h1, 4'h0}, 24'hFFFFF0);
		go(CALDP_OP_PXFER, 0, 0, 1, 16'h0, 16'h55AA, 8'h00, {16'h00AA, 4'h2, 4'h0}, 24'hFFFFF0);
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		repeat (3) @(posedge clk);
		compares++;
		if (q.size() != 0) begin
			bad_count++;
			$display("[ERR] pending exp 0 got %0d", q.size());
		end
		stop_test();
	end
endmodule : tb

bind caldp_core caldp_props u_props(.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
	.rsp_valid(rsp_valid), .rsp(rsp), .flags(flags));
